// File: rtl/kbd_pkg.sv
// Purpose: shared constants and types for the keyboard serial transmitter
// Assumes: core_clk at 250 MHz
// Notes:   word layout is eight data bits, LSB first, then one stop bit
package kbd_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ     = 250_000_000;
    localparam int unsigned ACK_TIMEOUT_MS  = 250;
    localparam int unsigned MS_PER_S        = 1000;
    localparam int unsigned ACK_TIMEOUT_CYC = (CLK_FREQ_HZ / MS_PER_S) * ACK_TIMEOUT_MS;
    localparam int unsigned TMR_W           = 26;

    // ------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned KEYNUM_W  = 7;
    localparam int unsigned BITCNT_W  = 4;
    localparam logic [BITCNT_W-1:0] BIT_FIRST = 4'h0;
    localparam logic [BITCNT_W-1:0] BIT_STOP  = 4'h8;
    localparam logic [BITCNT_W-1:0] BIT_STEP  = 4'h1;

    // ------------------------------------------------------------
    // line levels and reserved codes
    // ------------------------------------------------------------
    localparam logic LINE_HIGH = 1'b1;
    localparam logic LINE_LOW  = 1'b0;
    localparam logic [DATA_BITS-1:0] CODE_OVERFLOW = 8'hfe;
    localparam logic [DATA_BITS-1:0] CODE_DEAD     = 8'hff;
    localparam logic [DATA_BITS-1:0] WORD_RESET    = 8'h00;

    // ------------------------------------------------------------
    // event kinds and transmitter states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EV_KEY      = 2'h0,
        EV_OVERFLOW = 2'h1,
        EV_DEAD     = 2'h2
    } event_kind_e;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h1,
        ST_SETUP     = 4'h2,
        ST_WAIT_FALL = 4'h4,
        ST_WAIT_RISE = 4'h8
    } tx_state_e;

endpackage : kbd_pkg

// File: rtl/ack_edge_sync.sv
// Purpose: bring the acknowledge pin into core_clk and find its edges
// Assumes: pin idles high
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module ack_edge_sync
    import kbd_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // pin side
    input  wire logic pinIn,
    // core side
    output logic      levelOut,
    output logic      riseOut,
    output logic      fallOut
);

    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= LINE_HIGH;
            sync_ff <= LINE_HIGH;
            prev_ff <= LINE_HIGH;
        end else begin
            meta_ff <= pinIn;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign levelOut = sync_ff;
    assign riseOut  = sync_ff & ~prev_ff;
    assign fallOut  = ~sync_ff & prev_ff;

endmodule : ack_edge_sync

// File: rtl/keyboard_serial_handshake.sv
// Purpose: keyboard side of the interlocked serial key event link
// Assumes: one event word at a time offered by the key scanner
// Notes:   ready and data lines idle high
`timescale 1ns/1ps
module keyboard_serial_handshake
    import kbd_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = ACK_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                arst_n,
    // key event request
    input  wire logic                eventValid,
    output logic                     eventReady,
    input  wire event_kind_e         eventKind,
    input  wire logic                keyClosed,
    input  wire logic [KEYNUM_W-1:0] keyNumber,
    // link pins
    input  wire logic                ackStrobeLine,
    output logic                     keyReadyLine,
    output logic                     keySerialLine,
    // status
    output logic                     linkBusy,
    output logic                     timeoutPulse
);

    tx_state_e            state_ff;
    logic [DATA_BITS-1:0] word_ff;
    logic [BITCNT_W-1:0]  bitCnt_ff;
    logic [TMR_W-1:0]     timer_ff;
    logic                 ready_ff;
    logic                 serial_ff;
    logic                 ackRise;
    logic                 ackFall;
    logic                 accept;
    logic                 timeoutHit;
    logic                 isStop;
    logic [DATA_BITS-1:0] nxt_word;

    // ------------------------------------------------------------
    // acknowledge pin synchroniser
    // ------------------------------------------------------------
    ack_edge_sync u_ack_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .pinIn    (ackStrobeLine),
        .levelOut (),
        .riseOut  (ackRise),
        .fallOut  (ackFall)
    );

    // ------------------------------------------------------------
    // event word building
    // ------------------------------------------------------------
    assign eventReady = (state_ff == ST_IDLE);
    assign accept     = eventValid & eventReady;
    assign isStop     = (bitCnt_ff == BIT_STOP);
    assign timeoutHit = (state_ff == ST_WAIT_FALL) && !ackFall
                        && (timer_ff == TMR_W'(TIMEOUT_CYCLES - 1));

    always_comb begin
        if (eventKind == EV_DEAD) begin
            nxt_word = CODE_DEAD;
        end else if (eventKind == EV_OVERFLOW) begin
            nxt_word = CODE_OVERFLOW;
        end else begin
            nxt_word = {keyClosed, keyNumber};
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            word_ff <= WORD_RESET;
        end else if (accept) begin
            word_ff <= nxt_word;
        end
    end

    // ------------------------------------------------------------
    // handshake sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff  <= ST_IDLE;
            bitCnt_ff <= BIT_FIRST;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (accept) begin
                        state_ff  <= ST_SETUP;
                        bitCnt_ff <= BIT_FIRST;
                    end
                end
                ST_SETUP: begin
                    state_ff <= ST_WAIT_FALL;
                end
                ST_WAIT_FALL: begin
                    if (ackFall) begin
                        state_ff <= ST_WAIT_RISE;
                    end else if (timeoutHit) begin
                        state_ff  <= ST_SETUP;
                        bitCnt_ff <= BIT_FIRST;
                    end
                end
                ST_WAIT_RISE: begin
                    if (ackRise) begin
                        if (isStop) begin
                            state_ff <= ST_IDLE;
                        end else begin
                            state_ff  <= ST_SETUP;
                            bitCnt_ff <= bitCnt_ff + BIT_STEP;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // response timer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_ff <= '0;
        end else if (state_ff == ST_WAIT_FALL && !timeoutHit) begin
            timer_ff <= timer_ff + TMR_W'(1);
        end else begin
            timer_ff <= '0;
        end
    end

    // ------------------------------------------------------------
    // line drivers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ready_ff <= LINE_HIGH;
        end else if (state_ff == ST_SETUP) begin
            ready_ff <= LINE_LOW;
        end else if (state_ff == ST_WAIT_FALL && (ackFall || timeoutHit)) begin
            ready_ff <= LINE_HIGH;
        end
    end

    // data moves on accept, after an acknowledge rise, at stop release, or on restart
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            serial_ff <= LINE_HIGH;
        end else if (accept) begin
            serial_ff <= nxt_word[BIT_FIRST[2:0]];
        end else if (state_ff == ST_WAIT_RISE && ackRise && !isStop) begin
            if (bitCnt_ff + BIT_STEP == BIT_STOP) begin
                serial_ff <= LINE_LOW;
            end else begin
                serial_ff <= word_ff[bitCnt_ff[2:0] + 3'h1];
            end
        end else if (state_ff == ST_WAIT_FALL && isStop && ackFall) begin
            serial_ff <= LINE_HIGH;
        end else if (timeoutHit) begin
            serial_ff <= word_ff[BIT_FIRST[2:0]];
        end
    end

    assign keyReadyLine  = ready_ff;
    assign keySerialLine = serial_ff;
    assign linkBusy      = (state_ff != ST_IDLE);
    assign timeoutPulse  = timeoutHit;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence stopWaitFall;
        (state_ff == ST_WAIT_FALL) && isStop;
    endsequence

    sequence stopReleased;
        keySerialLine && keyReadyLine && (state_ff == ST_WAIT_RISE);
    endsequence

    ready_open_setup_a: assert property (
        $fell(keyReadyLine) |-> $past(state_ff == ST_SETUP))
        else $error("ready line fell outside a bit setup");

    ready_ack_fall_a: assert property (
        (state_ff == ST_WAIT_FALL) && ackFall |=> keyReadyLine && (state_ff == ST_WAIT_RISE))
        else $error("ready line not raised after acknowledge fall");

    data_change_cause_a: assert property (
        $changed(keySerialLine) |-> $past(accept) || $past(ackRise) || $past(timeoutHit)
                                    || ($past(ackFall) && $past(isStop)))
        else $error("serial line changed without cause");

    data_before_ready_a: assert property (
        !keyReadyLine |-> $stable(keySerialLine) && $past(keySerialLine, 1) == keySerialLine)
        else $error("serial line moved while ready low");

    stop_low_a: assert property (
        stopWaitFall |-> !keySerialLine)
        else $error("stop bit not low during ready low");

    stop_release_a: assert property (
        stopWaitFall ##0 ackFall |=> stopReleased)
        else $error("stop bit release did not raise both lines");

    stop_idle_a: assert property (
        (state_ff == ST_WAIT_RISE) && isStop && ackRise |=> eventReady && keySerialLine)
        else $error("link not idle after final acknowledge rise");

    data_bit_value_a: assert property (
        (state_ff == ST_SETUP) && !isStop |-> keySerialLine == word_ff[bitCnt_ff[2:0]])
        else $error("serial line does not carry the indexed data bit");

    key_word_format_a: assert property (
        accept && (eventKind != EV_OVERFLOW) && (eventKind != EV_DEAD)
        |=> word_ff == {$past(keyClosed), $past(keyNumber)})
        else $error("key word layout wrong");

    timeout_restart_a: assert property (
        timeoutHit |=> keyReadyLine && (state_ff == ST_SETUP) && (bitCnt_ff == BIT_FIRST)
                       ##1 !keyReadyLine)
        else $error("timeout did not restart the word");

    reserved_code_a: assert property (
        accept && ((eventKind == EV_OVERFLOW) || (eventKind == EV_DEAD))
        |=> word_ff == (($past(eventKind) == EV_DEAD) ? CODE_DEAD : CODE_OVERFLOW))
        else $error("reserved code not loaded");

endmodule : keyboard_serial_handshake

// File: testbench/term_proc_model.sv
// Purpose: processor side of the key link, answers ready transitions
// Assumes: ready and data lines idle high
// Notes:   mute stops all answers so the keyboard times out
`timescale 1ns/1ps
module term_proc_model (
    // clock
    input  wire logic       core_clk,
    // link pins
    input  wire logic       keyReadyLine,
    input  wire logic       keySerialLine,
    output logic            ackStrobeLine,
    // control and capture
    input  wire logic       mute,
    input  wire logic [3:0] ackDelay,
    output logic [8:0]      rxWord,
    output int              rxCount
);
    initial begin
        ackStrobeLine = 1'b1;
        rxWord        = '0;
        rxCount       = 0;
        forever begin
            @(posedge core_clk);
            if (keyReadyLine === 1'b0 && mute === 1'b0) begin
                rxWord <= {keySerialLine, rxWord[8:1]};
                repeat (ackDelay) @(posedge core_clk);
                ackStrobeLine <= 1'b0;
                do @(posedge core_clk);
                while (keyReadyLine !== 1'b1);
                repeat (ackDelay) @(posedge core_clk);
                ackStrobeLine <= 1'b1;
                rxCount       <= rxCount + 1;
            end
        end
    end
endmodule : term_proc_model

// File: testbench/tb_top.sv
// Purpose: self-checking bench for the keyboard serial transmitter
// Assumes: processor model answers every ready transition except while mute is set
// Notes:   ack timeout shortened to 64 cycles
`timescale 1ns/1ps
module tb_top;
    import kbd_pkg::*;
    localparam int unsigned TMO  = 64;
    localparam int          CEIL = 20000;
    typedef struct {
        logic [1:0] kind;
        logic       closed;
        logic [6:0] num;
        logic [7:0] exp;
    } row_s;
    row_s rows [6] = '{'{2'h0, 1'b1, 7'h7f, 8'hff}, '{2'h0, 1'b0, 7'h00, 8'h00},
                       '{2'h0, 1'b1, 7'h2a, 8'haa}, '{2'h1, 1'b0, 7'h55, 8'hfe},
                       '{2'h2, 1'b1, 7'h00, 8'hff}, '{2'h3, 1'b0, 7'h35, 8'h35}};
    logic                core_clk;
    logic                arst_n = 1'b0;
    logic                eventValid = 1'b0;
    event_kind_e         eventKind = EV_KEY;
    logic                keyClosed = 1'b0;
    logic [KEYNUM_W-1:0] keyNumber = 7'h00;
    logic                mute = 1'b0;
    logic [3:0]          ackDelay = 4'h0;
    logic                ackStrobeLine, keyReadyLine, keySerialLine;
    logic                eventReady, linkBusy, timeoutPulse;
    logic                prevReady = 1'b1;
    logic                prevSerial = 1'b1;
    logic [8:0]          rxWord;
    int                  rxCount, lowCyc;
    int                  mismatches = 0;
    int                  testsRun = 0;
    int                  cycles = 0;

    keyboard_serial_handshake #(.TIMEOUT_CYCLES(TMO)) keyboard_serial_handshake_i (
        .core_clk(core_clk), .arst_n(arst_n), .eventValid(eventValid),
        .eventReady(eventReady), .eventKind(eventKind), .keyClosed(keyClosed),
        .keyNumber(keyNumber), .ackStrobeLine(ackStrobeLine), .keyReadyLine(keyReadyLine),
        .keySerialLine(keySerialLine), .linkBusy(linkBusy), .timeoutPulse(timeoutPulse));
    term_proc_model term_proc_model_i (
        .core_clk(core_clk), .keyReadyLine(keyReadyLine), .keySerialLine(keySerialLine),
        .ackStrobeLine(ackStrobeLine), .mute(mute), .ackDelay(ackDelay),
        .rxWord(rxWord), .rxCount(rxCount));

    // ------------------------------------------------------------
    // checking and driving tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        if (mismatches == 0 && testsRun > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check_bit(input string name, input logic exp, input logic got);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : check_bit

    task automatic check_word(input string name, input logic [8:0] exp, input logic [8:0] got);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word

    task automatic send(input logic [1:0] k, input logic c, input logic [6:0] n);
        do @(negedge core_clk);
        while (eventReady !== 1'b1);
        @(posedge core_clk);
        eventValid <= 1'b1;
        eventKind  <= event_kind_e'(k);
        keyClosed  <= c;
        keyNumber  <= n;
        @(posedge core_clk);
        eventValid <= 1'b0;
    endtask : send

    task automatic get_word(input logic [7:0] exp);
        int start;
        start = rxCount;
        while (rxCount != start + 9) @(negedge core_clk);
        while (eventReady !== 1'b1) @(negedge core_clk);
        check_word("word", {1'b0, exp}, rxWord);
        check_bit("ready idle", 1'b1, keyReadyLine);
        check_bit("serial idle", 1'b1, keySerialLine);
        check_bit("busy", 1'b0, linkBusy);
    endtask : get_word

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles     <= cycles + 1;
        prevReady  <= keyReadyLine;
        prevSerial <= keySerialLine;
        if (arst_n && keySerialLine !== prevSerial) begin
            check_bit("serial held while ready low", 1'b1, prevReady | keyReadyLine);
            check_bit("serial change after ack rise", 1'b1, ackStrobeLine | keyReadyLine);
        end
        if (cycles == CEIL) begin
            mismatches++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        check_bit("reset ready", 1'b1, keyReadyLine);
        check_bit("reset serial", 1'b1, keySerialLine);
        check_bit("reset accept", 1'b1, eventReady);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            @(posedge core_clk);
            ackDelay <= 4'(i * 3);
            send(rows[i].kind, rows[i].closed, rows[i].num);
            get_word(rows[i].exp);
        end
        // a second request is held off until the first word ends
        send(2'h0, 1'b0, 7'h0f);
        @(posedge core_clk);
        eventValid <= 1'b1;
        eventKind  <= EV_OVERFLOW;
        @(negedge core_clk);
        check_bit("refused while busy", 1'b0, eventReady);
        get_word(8'h0f);
        @(posedge core_clk);
        eventValid <= 1'b0;
        get_word(8'hfe);
        // silent processor forces a restart of the word
        @(posedge core_clk);
        mute   <= 1'b1;
        lowCyc = 0;
        send(2'h0, 1'b1, 7'h11);
        while (timeoutPulse !== 1'b1) begin
            @(negedge core_clk);
            if (keyReadyLine === 1'b0)
                lowCyc++;
        end
        check_bit("timeout moment", 1'b1, lowCyc >= TMO - 1 && lowCyc <= TMO + 1);
        @(negedge core_clk);
        check_bit("ready raised on timeout", 1'b1, keyReadyLine);
        @(posedge core_clk);
        mute <= 1'b0;
        get_word(8'h91);
        give_verdict();
    end
endmodule : tb_top
